// ===== design/src_out_regs.sv
// Output stage control, ratio readback, page selection and channel status buffers.
// Assumes a decoded byte-wide host port, one-cycle strobes, all on clk_sys.
`timescale 1ns/1ps
module src_out_regs
	import src_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic host_wr,
	input wire logic host_rd,
	input wire logic [6:0] host_addr,
	input wire logic [7:0] host_wdata,
	output logic [7:0] host_rdata,
	output logic host_rvalid,
	input wire logic track_en,
	input wire logic smp_valid,
	input wire logic signed [23:0] left_in,
	input wire logic signed [23:0] right_in,
	output logic signed [23:0] left_out,
	output logic signed [23:0] right_out,
	output logic out_valid,
	input wire logic [15:0] ratio_meas,
	input wire logic rx_cs_we,
	input wire logic rx_cs_chan,
	input wire logic [4:0] rx_cs_byte,
	input wire logic [7:0] rx_cs_wdata,
	input wire logic tx_cs_chan,
	input wire logic [4:0] tx_cs_byte,
	output logic [7:0] tx_cs_rdata,
	output logic rx_prof_mode,
	output logic tx_prof_mode
);
	logic [1:0] rst_sync_reg;
	logic rst_int_n;
	logic [1:0] wl_reg;
	logic [7:0] atten_l_reg;
	logic [7:0] atten_r_reg;
	logic [1:0] page_reg;
	logic [7:0] ratio_lo_hold_reg;
	logic [7:0] applied_l_reg;
	logic [7:0] applied_r_reg;
	logic [1:0] applied_wl_reg;
	logic [31:0] lfsr_reg;
	logic [7:0] rx_mem [CS_DEPTH];
	logic [7:0] tx_mem [CS_DEPTH];
	logic [4:0] crc_idx_reg;
	logic crc_ch_reg;
	logic [7:0] crc_run_reg;
	logic [7:0] crc_val_reg [2];
	logic [7:0] rdata_next;

	// Reset release through two flip-flops
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rst_sync_reg <= 2'h0;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_int_n = rst_sync_reg[1];

	// Host access decode; the page register answers on every page
	wire page_hit = (host_addr == ADDR_PAGE);
	wire on_ctrl = (page_reg == PAGE_CTRL) && !page_hit;
	wire in_cs = (host_addr < ADDR_CS_END) && !page_hit;
	wire [5:0] host_idx = host_addr[5:0];
	wire wr_page = host_wr && page_hit;
	wire wr_wl = host_wr && on_ctrl && (host_addr == ADDR_WORD_LEN);
	wire wr_al = host_wr && on_ctrl && (host_addr == ADDR_ATTEN_L);
	wire wr_ar = host_wr && on_ctrl && (host_addr == ADDR_ATTEN_R);
	wire wr_tx = host_wr && in_cs && (page_reg == PAGE_TX);
	wire rd_ratio_hi = host_rd && on_ctrl && (host_addr == ADDR_RATIO_HI);
	wire [5:0] rx_idx = {rx_cs_byte, rx_cs_chan};
	wire [5:0] tx_idx = {tx_cs_byte, tx_cs_chan};

	// Control registers written by the host
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			wl_reg <= RST_WL;
			atten_l_reg <= RST_ATTEN;
			atten_r_reg <= RST_ATTEN;
			page_reg <= RST_PAGE;
		end else begin
			if (wr_wl) wl_reg <= host_wdata[WL_MSB:WL_LSB];
			if (wr_al) atten_l_reg <= host_wdata;
			if (wr_ar) atten_r_reg <= host_wdata;
			if (wr_page) page_reg <= host_wdata[1:0];
		end
	end

	// Buffers: receiver side fills page 1, host fills page 2
	always_ff @(posedge clk_sys) begin
		if (rx_cs_we) rx_mem[rx_idx] <= rx_cs_wdata;
		if (wr_tx) tx_mem[host_idx] <= host_wdata;
	end

	// Read selection for the page register and pages 0 to 2; reserved bits and page 3 read as zero
	always_comb begin
		rdata_next = 8'h00;
		if (page_hit) begin
			rdata_next = {6'h00, page_reg};
		end else begin
			unique case (page_reg)
				PAGE_CTRL: begin
					if (host_addr == ADDR_WORD_LEN) rdata_next = {wl_reg, 6'h00};
					else if (host_addr == ADDR_ATTEN_L) rdata_next = atten_l_reg;
					else if (host_addr == ADDR_ATTEN_R) rdata_next = atten_r_reg;
					else if (host_addr == ADDR_RATIO_HI) rdata_next = ratio_meas[15:8];
					else if (host_addr == ADDR_RATIO_LO) rdata_next = ratio_lo_hold_reg;
				end
				PAGE_RX: if (in_cs) rdata_next = rx_mem[host_idx];
				PAGE_TX: if (in_cs) rdata_next = tx_mem[host_idx];
				PAGE_RSVD: rdata_next = 8'h00;
			endcase
		end
	end

	// Read answer one cycle after the strobe; ratio low byte caught with the high byte
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			host_rdata <= 8'h00;
			host_rvalid <= 1'b0;
			ratio_lo_hold_reg <= 8'h00;
		end else begin
			host_rvalid <= host_rd;
			if (host_rd) host_rdata <= rdata_next;
			if (rd_ratio_hi) ratio_lo_hold_reg <= ratio_meas[7:0];
		end
	end

	// Settings move to the datapath only at a sample strobe
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			applied_l_reg <= RST_ATTEN;
			applied_r_reg <= RST_ATTEN;
			applied_wl_reg <= RST_WL;
			out_valid <= 1'b0;
		end else begin
			out_valid <= smp_valid;
			if (smp_valid) begin
				applied_l_reg <= atten_l_reg;
				applied_r_reg <= track_en ? atten_l_reg : atten_r_reg;
				applied_wl_reg <= wl_reg;
			end
		end
	end

	// Dither source, advanced once per sample
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			lfsr_reg <= LFSR_SEED;
		end else if (smp_valid) begin
			lfsr_reg <= {lfsr_reg[30:0], lfsr_reg[31] ^ lfsr_reg[21] ^ lfsr_reg[1] ^ lfsr_reg[0]};
		end
	end

	ch_cfg_if cfg_l ();
	ch_cfg_if cfg_r ();
	assign cfg_l.atten = applied_l_reg;
	assign cfg_l.wl = applied_wl_reg;
	assign cfg_l.rnd_a = lfsr_reg[15:0];
	assign cfg_l.rnd_b = lfsr_reg[31:16];
	assign cfg_r.atten = applied_r_reg;
	assign cfg_r.wl = applied_wl_reg;
	assign cfg_r.rnd_a = lfsr_reg[23:8];
	assign cfg_r.rnd_b = {lfsr_reg[7:0], lfsr_reg[31:24]};

	out_chan u_left (.clk_sys(clk_sys), .rst_n(rst_int_n), .smp_valid(smp_valid), .din(left_in),
		.cfg(cfg_l), .dout(left_out));
	out_chan u_right (.clk_sys(clk_sys), .rst_n(rst_int_n), .smp_valid(smp_valid), .din(right_in),
		.cfg(cfg_r), .dout(right_out));

	// Background CRC over bytes 0..22 of each channel, alternating channels
	wire [7:0] crc_byte_in = tx_mem[{crc_idx_reg, crc_ch_reg}];
	wire [7:0] crc_step_out = crc_step(crc_run_reg, crc_byte_in);
	wire crc_last = (crc_idx_reg == CRC_BYTE - 5'h01);
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			crc_idx_reg <= 5'h00;
			crc_ch_reg <= 1'b0;
			crc_run_reg <= CRC_INIT;
			crc_val_reg <= '{8'h00, 8'h00};
		end else if (crc_last) begin
			crc_val_reg[crc_ch_reg] <= crc_step_out;
			crc_run_reg <= CRC_INIT;
			crc_idx_reg <= 5'h00;
			crc_ch_reg <= !crc_ch_reg;
		end else begin
			crc_run_reg <= crc_step_out;
			crc_idx_reg <= crc_idx_reg + 5'h01;
		end
	end

	// Mode bits and transmitter fetch; byte 23 replaced by the CRC in professional mode
	assign rx_prof_mode = rx_mem[0][PROF_POS];
	wire tx_prof_ch = tx_mem[{5'h00, tx_cs_chan}][PROF_POS];
	assign tx_prof_mode = tx_mem[0][PROF_POS];
	wire use_crc = tx_prof_ch && (tx_cs_byte == CRC_BYTE);
	always_ff @(posedge clk_sys or negedge rst_int_n) begin
		if (!rst_int_n) begin
			tx_cs_rdata <= 8'h00;
		end else begin
			tx_cs_rdata <= use_crc ? crc_val_reg[tx_cs_chan] : tx_mem[tx_idx];
		end
	end

	// Checks
	property p_page_read;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && page_hit) |=> (host_rvalid && host_rdata == {6'h00, $past(page_reg)});
	endproperty
	a_page_read: assert property (p_page_read) else $error("page read wrong");
	property p_wl_read;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && on_ctrl && host_addr == ADDR_WORD_LEN) |=> (host_rdata == {$past(wl_reg), 6'h00});
	endproperty
	a_wl_read: assert property (p_wl_read) else $error("word length read wrong");
	property p_ratio_hi;
		@(posedge clk_sys) disable iff (!rst_int_n)
		rd_ratio_hi |=> (host_rdata == $past(ratio_meas[15:8]) && ratio_lo_hold_reg == $past(ratio_meas[7:0]));
	endproperty
	a_ratio_hi: assert property (p_ratio_hi) else $error("ratio capture wrong");
	property p_ratio_coherent;
		@(posedge clk_sys) disable iff (!rst_int_n)
		rd_ratio_hi ##1 (!rd_ratio_hi [*2]) |-> $stable(ratio_lo_hold_reg);
	endproperty
	a_ratio_coherent: assert property (p_ratio_coherent) else $error("ratio hold moved");
	property p_track;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(smp_valid && track_en) |=> (applied_r_reg == applied_l_reg);
	endproperty
	a_track: assert property (p_track) else $error("right not tracking left");
	property p_untracked;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(smp_valid && !track_en) |=> (applied_r_reg == $past(atten_r_reg));
	endproperty
	a_untracked: assert property (p_untracked) else $error("right code not own");
	property p_sample_boundary;
		@(posedge clk_sys) disable iff (!rst_int_n)
		!smp_valid |=> ($stable(applied_l_reg) && $stable(applied_r_reg));
	endproperty
	a_sample_boundary: assert property (p_sample_boundary) else $error("gain changed mid sample");
	property p_trunc16;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(smp_valid && applied_wl_reg == WL_16) |=> (left_out[7:0] == 8'h00 && right_out[7:0] == 8'h00);
	endproperty
	a_trunc16: assert property (p_trunc16) else $error("16-bit output has low bits");
	property p_page3_zero;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && !page_hit && page_reg == PAGE_RSVD) |=> (host_rdata == 8'h00);
	endproperty
	a_page3_zero: assert property (p_page3_zero) else $error("reserved page not zero");
	property p_crc_byte;
		@(posedge clk_sys) disable iff (!rst_int_n)
		use_crc |=> (tx_cs_rdata == $past(crc_val_reg[tx_cs_chan]));
	endproperty
	a_crc_byte: assert property (p_crc_byte) else $error("CRC byte not sent");
	property p_ratio_lo;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && on_ctrl && host_addr == ADDR_RATIO_LO) |=> (host_rdata == $past(ratio_lo_hold_reg));
	endproperty
	a_ratio_lo: assert property (p_ratio_lo) else $error("ratio low byte not the held one");
	property p_rx_read;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && in_cs && page_reg == PAGE_RX) |=> (host_rdata == $past(rx_mem[host_idx]));
	endproperty
	a_rx_read: assert property (p_rx_read) else $error("receiver buffer read wrong");
	property p_tx_read;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_rd && in_cs && page_reg == PAGE_TX) |=> (host_rdata == $past(tx_mem[host_idx]));
	endproperty
	a_tx_read: assert property (p_tx_read) else $error("transmitter buffer read wrong");
	property p_ctrl_write_page;
		@(posedge clk_sys) disable iff (!rst_int_n)
		(host_wr && page_reg != PAGE_CTRL && !page_hit) |=> ($stable(atten_l_reg) && $stable(atten_r_reg) && $stable(wl_reg));
	endproperty
	a_ctrl_write_page: assert property (p_ctrl_write_page) else $error("control written off page 0");
	property p_apply;
		@(posedge clk_sys) disable iff (!rst_int_n)
		smp_valid |=> (applied_wl_reg == $past(wl_reg) && applied_l_reg == $past(atten_l_reg));
	endproperty
	a_apply: assert property (p_apply) else $error("settings not applied at strobe");
	property p_read_answer;
		@(posedge clk_sys) disable iff (!rst_int_n)
		host_rd |=> host_rvalid;
	endproperty
	a_read_answer: assert property (p_read_answer) else $error("read not answered");
	c_page_switch: cover property (@(posedge clk_sys) disable iff (!rst_int_n) wr_page ##[1:4] host_rd);
	c_ratio_pair: cover property (@(posedge clk_sys) disable iff (!rst_int_n)
		rd_ratio_hi ##[1:4] (host_rd && on_ctrl && host_addr == ADDR_RATIO_LO));
	c_crc_fetch: cover property (@(posedge clk_sys) disable iff (!rst_int_n) use_crc);
	c_tracked: cover property (@(posedge clk_sys) disable iff (!rst_int_n) smp_valid && track_en);
endmodule

// ===== design/src_out_pkg.sv
// Constants for the rate converter output stage and host page map.
// Assumes a byte-wide host register port already decoded from the serial host interface.
package src_out_pkg;
	// Page 0 register offsets
	localparam logic [6:0] ADDR_WORD_LEN = 7'h2F;
	localparam logic [6:0] ADDR_ATTEN_L = 7'h30;
	localparam logic [6:0] ADDR_ATTEN_R = 7'h31;
	localparam logic [6:0] ADDR_RATIO_HI = 7'h32;
	localparam logic [6:0] ADDR_RATIO_LO = 7'h33;
	localparam logic [6:0] ADDR_PAGE = 7'h7F;
	// Buffer window on pages 1 and 2: 24 bytes per channel, interleaved
	localparam logic [6:0] ADDR_CS_END = 7'h30;
	localparam int CS_DEPTH = 48;
	localparam logic [4:0] CRC_BYTE = 5'h17;
	localparam logic [7:0] CRC_INIT = 8'hFF;
	localparam logic [7:0] CRC_POLY = 8'h1D;
	// Stored bit 7 holds channel status bit 0 (MSB-first storage)
	localparam int PROF_POS = 7;
	// Field positions
	localparam int WL_MSB = 7;
	localparam int WL_LSB = 6;
	// Page codes
	localparam logic [1:0] PAGE_CTRL = 2'h0;
	localparam logic [1:0] PAGE_RX = 2'h1;
	localparam logic [1:0] PAGE_TX = 2'h2;
	localparam logic [1:0] PAGE_RSVD = 2'h3;
	// Word length codes and dropped low bits
	localparam logic [1:0] WL_24 = 2'h0;
	localparam logic [1:0] WL_20 = 2'h1;
	localparam logic [1:0] WL_18 = 2'h2;
	localparam logic [1:0] WL_16 = 2'h3;
	localparam logic [4:0] DROP_24 = 5'h00;
	localparam logic [4:0] DROP_20 = 5'h04;
	localparam logic [4:0] DROP_18 = 5'h06;
	localparam logic [4:0] DROP_16 = 5'h08;
	// Reset values
	localparam logic [1:0] RST_WL = 2'h0;
	localparam logic [7:0] RST_ATTEN = 8'h00;
	localparam logic [1:0] RST_PAGE = 2'h0;
	localparam logic [31:0] LFSR_SEED = 32'hACE1_0001;
	// Attenuation: 0.5 dB steps, 12 steps per halving; gain mantissa in Q16
	localparam logic [7:0] STEPS_PER_HALF = 8'h0C;
	localparam int GAIN_FRAC = 16;
	localparam logic [16:0] GAIN_MANT [12] = '{
		17'h1_0000, 17'h0_F1AE, 17'h0_E429, 17'h0_D766, 17'h0_CB59, 17'h0_BFF9,
		17'h0_B53C, 17'h0_AB19, 17'h0_A186, 17'h0_987D, 17'h0_8FF6, 17'h0_87E8};

	// Low bits removed for a word length code
	function automatic logic [4:0] wl_drop(input logic [1:0] wl);
		case (wl)
			WL_20: wl_drop = DROP_20;
			WL_18: wl_drop = DROP_18;
			WL_16: wl_drop = DROP_16;
			default: wl_drop = DROP_24;
		endcase
	endfunction

	// One byte into the channel status CRC, stored MSB sent first
	function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		logic fb;
		c = crc;
		for (int i = 7; i >= 0; i--) begin
			fb = c[7] ^ data[i];
			c = {c[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
		end
		crc_step = c;
	endfunction
endpackage

// ===== design/ch_cfg_if.sv
// Per-channel settings carried from the register bank to a channel datapath.
// Assumes both ends run on clk_sys.
`timescale 1ns/1ps
interface ch_cfg_if;
	logic [7:0] atten;
	logic [1:0] wl;
	logic [15:0] rnd_a;
	logic [15:0] rnd_b;
	modport drv (output atten, output wl, output rnd_a, output rnd_b);
	modport chn (input atten, input wl, input rnd_a, input rnd_b);
endinterface

// ===== design/out_chan.sv
// One output channel: attenuation, TPDF dither and word length reduction.
// Assumes settings on cfg are held steady between sample strobes.
`timescale 1ns/1ps
module out_chan
	import src_out_pkg::*;
(
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic smp_valid,
	input wire logic signed [23:0] din,
	ch_cfg_if.chn cfg,
	output logic signed [23:0] dout
);
	localparam logic signed [25:0] MAX24 = 26'sh07F_FFFF;
	localparam logic signed [25:0] MIN24 = -26'sh080_0000;

	// Gain = mantissa of the half-step remainder, shifted by whole 6 dB steps
	wire [3:0] step_idx = 4'(cfg.atten % STEPS_PER_HALF);
	wire [4:0] shift = 5'(cfg.atten / STEPS_PER_HALF);
	wire [16:0] mant = GAIN_MANT[step_idx];
	wire signed [41:0] prod = din * $signed({1'b0, mant});
	wire signed [41:0] scaled = prod >>> (6'(GAIN_FRAC) + 6'(shift));

	// Triangular dither: mean of two uniform values below the kept LSB
	wire [4:0] drop = wl_drop(cfg.wl);
	wire [15:0] dmask = 16'((17'h0_0001 << drop) - 17'h0_0001);
	wire [16:0] dith = ({1'b0, cfg.rnd_a & dmask} + {1'b0, cfg.rnd_b & dmask}) >> 1;
	wire signed [25:0] summed = 26'(scaled) + $signed({9'h000, dith});
	wire signed [25:0] sat = (summed > MAX24) ? MAX24 : ((summed < MIN24) ? MIN24 : summed);
	wire signed [23:0] kept = sat[23:0] & ~{8'h00, dmask};

	// Output register moves only on a sample strobe
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			dout <= '0;
		end else if (smp_valid) begin
			dout <= kept;
		end
	end
endmodule

// ===== verification/host_model.sv
// Host controller model: byte-wide register writes and reads on the decoded host port.
// Assumes the device takes a strobe on a rising clk_sys edge and answers reads with a valid pulse.
`timescale 1ns/1ps
module host_model (
	input wire logic clk_sys,
	input wire logic [7:0] host_rdata,
	input wire logic host_rvalid,
	output logic host_wr,
	output logic host_rd,
	output logic [6:0] host_addr,
	output logic [7:0] host_wdata
);
	// Idle bus at time zero
	initial begin
		host_wr = 1'b0;
		host_rd = 1'b0;
		host_addr = 7'h00;
		host_wdata = 8'h00;
	end
	// One write strobe; released lines show the inverse so stale values cannot pass
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge clk_sys);
		host_wr = 1'b1;
		host_addr = a;
		host_wdata = d;
		@(negedge clk_sys);
		host_wr = 1'b0;
		host_addr = ~a;
		host_wdata = ~d;
	endtask
	// One read strobe; data taken with the valid pulse under a bounded wait
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		int n;
		@(negedge clk_sys);
		host_rd = 1'b1;
		host_addr = a;
		@(negedge clk_sys);
		host_rd = 1'b0;
		host_addr = ~a;
		d = 8'hxx;
		for (n = 0; n < 3 && host_rvalid !== 1'b1; n++) @(negedge clk_sys);
		if (host_rvalid === 1'b1) d = host_rdata;
	endtask
endmodule

// ===== verification/src_out_regs_tb_top.sv
// Self-checking bench for the output stage register bank, page map and status buffers.
// Assumes host_model drives the host port; all other inputs change at the falling edge.
`timescale 1ns/1ps
module src_out_regs_tb_top;
	import src_out_pkg::*;
	logic clk_sys, rst_n, host_wr, host_rd, host_rvalid, track_en, smp_valid, out_valid;
	logic rx_cs_we, rx_cs_chan, tx_cs_chan, rx_prof_mode, tx_prof_mode;
	logic [6:0] host_addr;
	logic [7:0] host_wdata, host_rdata, tx_cs_rdata, rx_cs_wdata;
	logic signed [23:0] left_in, right_in, left_out, right_out;
	logic [15:0] ratio_meas;
	logic [4:0] rx_cs_byte, tx_cs_byte;
	logic [7:0] cs [48];
	int fail_count = 0;
	int checks_done = 0;
	src_out_regs src_out_regs_inst (.clk_sys(clk_sys), .rst_n(rst_n), .host_wr(host_wr), .host_rd(host_rd),
		.host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.track_en(track_en), .smp_valid(smp_valid), .left_in(left_in), .right_in(right_in),
		.left_out(left_out), .right_out(right_out), .out_valid(out_valid), .ratio_meas(ratio_meas),
		.rx_cs_we(rx_cs_we), .rx_cs_chan(rx_cs_chan), .rx_cs_byte(rx_cs_byte), .rx_cs_wdata(rx_cs_wdata),
		.tx_cs_chan(tx_cs_chan), .tx_cs_byte(tx_cs_byte), .tx_cs_rdata(tx_cs_rdata),
		.rx_prof_mode(rx_prof_mode), .tx_prof_mode(tx_prof_mode));
	host_model host_model_inst (.clk_sys(clk_sys), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
		.host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata));
	// 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Compare exactly, or within a tolerance for dithered or scaled samples
	task automatic chk(input string nm, input logic [23:0] exp, input logic [23:0] got, input int tol);
		int d;
		d = int'($signed(got)) - int'($signed(exp));
		checks_done++;
		if ((tol == 0) ? (got !== exp) : (^got === 1'bx || d > tol || d < -tol)) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// One sample strobe, then wait for the output pulse
	task automatic smp(input logic signed [23:0] x);
		int n;
		@(negedge clk_sys);
		smp_valid = 1'b1;
		left_in = x;
		right_in = x;
		@(negedge clk_sys);
		smp_valid = 1'b0;
		left_in = ~x;
		right_in = ~x;
		for (n = 0; n < 3 && out_valid !== 1'b1; n++) @(negedge clk_sys);
	endtask
	// Channel status CRC of one channel's bytes 0..22, stored bit 7 sent first
	function automatic logic [7:0] crc_of(input int ch);
		logic [7:0] c;
		c = CRC_INIT;
		for (int b = 0; b < 23; b++)
			for (int i = 7; i >= 0; i--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ cs[2 * b + ch][i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction
	task automatic give_verdict;
		if (fail_count == 0 && checks_done > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	// Watchdog well beyond the expected run length
	initial begin
		#2_000_000;
		fail_count++;
		give_verdict();
	end
	initial begin
		logic [7:0] d;
		logic [15:0] rt;
		logic signed [23:0] x;
		int sh;
		int up;
		{rst_n, track_en, smp_valid, rx_cs_we, rx_cs_chan, tx_cs_chan} = 6'h00;
		{left_in, right_in} = 48'h0000_0000_0000;
		ratio_meas = 16'h0000;
		{rx_cs_byte, tx_cs_byte, rx_cs_wdata} = 18'h0_0000;
		d = $urandom(32'h8bf9);
		repeat (4) @(posedge clk_sys);
		@(negedge clk_sys);
		rst_n = 1'b1;
		repeat (3) @(posedge clk_sys);
		// Reset values of control registers and page
		host_model_inst.rd(ADDR_WORD_LEN, d);
		chk("word_len reset", 24'h0, d, 0);
		host_model_inst.rd(ADDR_ATTEN_L, d);
		chk("atten_l reset", 24'h0, d, 0);
		host_model_inst.rd(ADDR_ATTEN_R, d);
		chk("atten_r reset", 24'h0, d, 0);
		host_model_inst.rd(ADDR_PAGE, d);
		chk("page reset", 24'h0, d, 0);
		// Every word length code; unused bits stay zero
		for (int w = 0; w < 4; w++) begin
			host_model_inst.wr(ADDR_WORD_LEN, {w[1:0], 6'h3F});
			host_model_inst.rd(ADDR_WORD_LEN, d);
			chk("word_len", {16'h0, w[1:0], 6'h00}, d, 0);
		end
		// Every page code with random upper bits; reserved page maps nothing
		for (int p = 0; p < 4; p++) begin
			rt = $urandom;
			host_model_inst.wr(ADDR_PAGE, {rt[5:0], p[1:0]});
			host_model_inst.rd(ADDR_PAGE, d);
			chk("page", {22'h0, p[1:0]}, d, 0);
		end
		host_model_inst.rd(ADDR_WORD_LEN, d);
		chk("page 3 read", 24'h0, d, 0);
		host_model_inst.wr(ADDR_PAGE, 8'h00);
		// Ratio readback: read-only, low byte captured at the high byte read
		rt = $urandom;
		ratio_meas = rt;
		host_model_inst.wr(ADDR_RATIO_HI, ~rt[15:8]);
		host_model_inst.rd(ADDR_RATIO_HI, d);
		chk("ratio_hi", rt[15:8], d, 0);
		ratio_meas = ~rt;
		host_model_inst.rd(ADDR_RATIO_LO, d);
		chk("ratio_lo", rt[7:0], d, 0);
		// Receiver buffer fill, then interleaved host readback on page 1
		for (int i = 0; i < 48; i++) begin
			cs[i] = $urandom;
			@(negedge clk_sys);
			rx_cs_we = 1'b1;
			rx_cs_chan = i[0];
			rx_cs_byte = i[5:1];
			rx_cs_wdata = cs[i];
		end
		@(negedge clk_sys);
		rx_cs_we = 1'b0;
		chk("rx_prof_mode", cs[0][7], rx_prof_mode, 0);
		host_model_inst.wr(ADDR_PAGE, 8'h01);
		host_model_inst.wr(7'h00, ~cs[0]);
		for (int i = 0; i < 48; i++) begin
			host_model_inst.rd(i[6:0], d);
			chk("rx buffer", cs[i], d, 0);
		end
		host_model_inst.rd(ADDR_CS_END, d);
		chk("rx past end", 24'h0, d, 0);
		host_model_inst.wr(ADDR_ATTEN_L, 8'hA5);
		// Transmitter buffer on page 2: channel 1 professional, channel 2 consumer
		host_model_inst.wr(ADDR_PAGE, 8'h02);
		for (int i = 0; i < 48; i++) begin
			cs[i] = $urandom;
			if (i < 2) cs[i][PROF_POS] = ~i[0];
			host_model_inst.wr(i[6:0], cs[i]);
		end
		repeat (100) @(negedge clk_sys);
		chk("tx_prof_mode", 24'h1, tx_prof_mode, 0);
		for (int i = 0; i < 48; i++) begin
			tx_cs_chan = i[0];
			tx_cs_byte = i[5:1];
			@(negedge clk_sys);
			@(negedge clk_sys);
			chk("tx_cs_rdata", (i >= 46 && cs[i[0]][7]) ? crc_of(i[0]) : cs[i], tx_cs_rdata, 0);
		end
		// Audio: unity pass, gain change at the sample boundary, tracking on and off
		host_model_inst.wr(ADDR_PAGE, 8'h00);
		host_model_inst.rd(ADDR_ATTEN_L, d);
		chk("atten_l after page 1 write", 24'h0, d, 0);
		host_model_inst.wr(ADDR_WORD_LEN, 8'h00);
		x = $signed(24'($urandom)) >>> 2;
		smp(x);
		smp(x);
		chk("left unity", x, left_out, 0);
		host_model_inst.wr(ADDR_ATTEN_L, 8'd24);
		smp(x);
		chk("left old gain", x, left_out, 0);
		smp(x);
		chk("left 12 dB", x >>> 2, left_out, 2);
		chk("right own", x, right_out, 0);
		track_en = 1'b1;
		host_model_inst.wr(ADDR_ATTEN_R, 8'd12);
		smp(x);
		smp(x);
		chk("right tracks", x >>> 2, right_out, 2);
		track_en = 1'b0;
		smp(x);
		smp(x);
		chk("right 6 dB", x >>> 1, right_out, 2);
		// Shorter word lengths: low bits cleared, dither bounded
		host_model_inst.wr(ADDR_ATTEN_L, 8'h00);
		up = 0;
		for (int w = 1; w < 4; w++) begin
			sh = (w == 1) ? 4 : (w == 2) ? 6 : 8;
			host_model_inst.wr(ADDR_WORD_LEN, {w[1:0], 6'h00});
			host_model_inst.rd(ADDR_WORD_LEN, d);
			chk("port word len", {16'h0, w[1:0], 6'h00}, d, 0);
			for (int k = 0; k < 4; k++) begin
				// Low bits all ones: any nonzero dither rounds the sample up
				x = ($signed(24'($urandom)) >>> 4) | 24'sh00_00FF;
				smp(x);
				if (k > 0 && left_out > x) up++;
				if (k > 0) chk("left low bits", 24'h0, left_out & ((24'h1 << sh) - 24'h1), 0);
				if (k > 0) chk("left dithered", x, left_out, 1 << sh);
			end
		end
		chk("dither rounds up", 24'h1, {23'h0, up > 0}, 0);
		give_verdict();
	end
endmodule
